// File: pkg/mcos_pkg.sv
// mcos_pkg: constants for the multi-chip output clock sync block
// assumes a 32-bit apb bus with word-aligned registers
package mcos_pkg;
  // register byte offsets
  localparam logic [7:0] MCOS_CTRL_OFS = 8'h00;
  localparam logic [7:0] MCOS_APER_OFS = 8'h04;
  localparam logic [7:0] MCOS_STAT_OFS = 8'h08;
  // control field positions
  localparam int MCOS_CTRL_ECM = 0;
  localparam int MCOS_CTRL_PULSE_EN = 1;
  localparam int MCOS_CTRL_DEMUX = 2;
  localparam int MCOS_CTRL_QTR = 3;
  localparam int MCOS_CTRL_MS_EN = 4;
  localparam int MCOS_CTRL_MS_SLAVE = 5;
  localparam int MCOS_CTRL_PSEL_LO = 6;
  // status field positions
  localparam int MCOS_STAT_PULSE = 0;
  localparam int MCOS_STAT_COUNT = 1;
  localparam int MCOS_STAT_SEEN = 2;
  localparam int MCOS_STAT_PHASE_LO = 4;
  localparam int MCOS_STAT_NPULSE_LO = 8;
  // values after reset
  localparam logic [7:0] MCOS_CTRL_RST = 8'h00;
  localparam logic [3:0] MCOS_APER_RST = 4'h0;
  // cycle counts from the first edge after release to the alignment edge
  localparam logic [2:0] MCOS_ALN_CYC_QTR = 3'h4;
  localparam logic [2:0] MCOS_ALN_CYC_ZERO = 3'h5;
  // fixed pipeline figures of the output clock path
  localparam int MCOS_ALIGN_LAT = 8;
  localparam int MCOS_OUT_DLY = 8;
  typedef enum logic [1:0] {
    MCOS_ALN_IDLE = 2'b00,
    MCOS_ALN_HELD = 2'b01,
    MCOS_ALN_COUNT = 2'b10
  } mcos_aln_t;
endpackage

// File: rtl/mcos_top.sv
// mcos_top: output clock alignment for a dual-channel converter, apb registers
// assumes clk is the sampling clock, link_clk the reference clock from a master
//
// Functional notes
// R01 - pulse-driven reset works only in extended control mode and is off after reset
// R02 - alignment pulse may be asserted at any moment, unrelated to the sampling clock
// R03 - in demux mode the output clock is held high while the pulse is asserted
// R04 - in non-demux mode the output clock keeps toggling while the pulse is asserted
// R05 - one narrow glitch may appear when the pulse is asserted
// R06 - quarter phase set: align 4 cycles after first edge following release
// R07 - quarter phase clear: align 5 cycles after first edge following release
// R08 - output clock resumes after a fixed output delay following alignment
// R09 - second and later pulses leave reset deterministically
// R10 - controller sends one throw-away pulse after each power-up
// R11 - controller programs the phase select field identically in every master
// R12 - master/slave alignment is controlled through registers only
// R13 - both channel output clocks are always in phase
// R14 - in demux mode a slave picks one of four phases from the master reference
// R15 - master/slave alignment is continuous and recovers by the next clock cycle
// R16 - output clock timing is latency plus output delay minus aperture delay
// R17 - masters align by pulse, slaves align to their master continuously
// R18 - pulse release is resynchronised before counting toward the alignment edge
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mcos_top #(
  parameter int ALIGN_LAT = mcos_pkg::MCOS_ALIGN_LAT,
  parameter int OUT_DLY = mcos_pkg::MCOS_OUT_DLY
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // alignment pulse pin
  input wire logic clock_align_pulse,
  // output clocks and reference to slaves
  output var logic in_phase_channel_out_clock,
  output var logic quadrature_channel_out_clock,
  output var logic sync_reference_out_a,
  output var logic sync_reference_out_b
);
  import mcos_pkg::*;

  localparam int DLY_LEN = ALIGN_LAT + OUT_DLY + 1;

  logic rst_s1_q;
  logic rst_s2_q;
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic [7:0] ctrl_q;
  logic [3:0] aper_q;
  logic pulse_s1_q;
  logic pulse_s2_q;
  logic pulse_s3_q;
  logic ref_tog_q;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  mcos_aln_t aln_q;
  logic [2:0] cnt_q;
  logic hold_q;
  logic align_q;
  logic seen_q;
  logic [7:0] npulse_q;
  logic [1:0] phase_q;
  logic [DLY_LEN-1:0] dly_q;
  logic [31:0] rdata_w;
  logic addr_ok_w;
  logic ecm_w;
  logic pulse_en_w;
  logic demux_w;
  logic qtr_w;
  logic ms_en_w;
  logic ms_slave_w;
  logic [1:0] psel_field_w;
  logic assert_w;
  logic release_w;
  logic ref_evt_w;
  logic [1:0] phase_adj_w;
  logic clk_raw_w;
  logic [4:0] tap_w;
  logic wr_w;
  logic rd_w;

  // reset release through two flops, one copy per domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1_q <= 1'b0;
      lrst_s2_q <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_s2_q <= lrst_s1_q;
    end
  end

  assign ecm_w = ctrl_q[MCOS_CTRL_ECM];
  assign pulse_en_w = ecm_w & ctrl_q[MCOS_CTRL_PULSE_EN]; // [R01]
  assign demux_w = ctrl_q[MCOS_CTRL_DEMUX];
  assign qtr_w = ctrl_q[MCOS_CTRL_QTR];
  assign ms_en_w = ctrl_q[MCOS_CTRL_MS_EN]; // [R12]
  assign ms_slave_w = ms_en_w & ctrl_q[MCOS_CTRL_MS_SLAVE];
  assign psel_field_w = ctrl_q[MCOS_CTRL_PSEL_LO +: 2]; // [R11]

  // apb: answer in the second access cycle, write lands at that edge
  assign wr_w = psel & penable & pready & pwrite;
  assign rd_w = psel & penable & ~pready;

  always_comb begin
    rdata_w = 32'h0000_0000;
    addr_ok_w = 1'b1;
    if (paddr == MCOS_CTRL_OFS) begin
      rdata_w[7:0] = ctrl_q;
    end else if (paddr == MCOS_APER_OFS) begin
      rdata_w[3:0] = aper_q;
    end else if (paddr == MCOS_STAT_OFS) begin
      rdata_w[MCOS_STAT_PULSE] = pulse_s2_q;
      rdata_w[MCOS_STAT_COUNT] = (aln_q == MCOS_ALN_COUNT);
      rdata_w[MCOS_STAT_SEEN] = seen_q;
      rdata_w[MCOS_STAT_PHASE_LO +: 2] = phase_q;
      rdata_w[MCOS_STAT_NPULSE_LO +: 8] = npulse_q;
    end else begin
      addr_ok_w = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_w;
      prdata <= rd_w ? rdata_w : 32'h0000_0000;
      pslverr <= rd_w & ~addr_ok_w;
    end
  end

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ctrl_q <= MCOS_CTRL_RST; // [R01]
      aper_q <= MCOS_APER_RST;
    end else if (wr_w && paddr == MCOS_CTRL_OFS) begin
      ctrl_q <= pwdata[7:0];
    end else if (wr_w && paddr == MCOS_APER_OFS) begin
      aper_q <= pwdata[3:0];
    end
  end

  // pulse pin is asynchronous: two flops, then an edge flop
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pulse_s1_q <= 1'b0;
      pulse_s2_q <= 1'b0;
      pulse_s3_q <= 1'b0;
    end else begin
      pulse_s1_q <= clock_align_pulse; // [R02]
      pulse_s2_q <= pulse_s1_q;
      pulse_s3_q <= pulse_s2_q;
    end
  end

  assign assert_w = pulse_s2_q & pulse_en_w;
  assign release_w = ~pulse_s2_q & pulse_s3_q; // [R18]

  // link domain: reference clock marks each master output clock period
  always_ff @(posedge link_clk or negedge lrst_s2_q) begin
    if (!lrst_s2_q) begin
      ref_tog_q <= 1'b0;
    end else begin
      ref_tog_q <= ~ref_tog_q;
    end
  end

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_tog_q;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  assign ref_evt_w = (ref_s2_q ^ ref_s3_q) & ms_slave_w; // [R15]

  // alignment sequencer for the pulse-driven reset
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      aln_q <= MCOS_ALN_IDLE;
      cnt_q <= 3'h0;
      hold_q <= 1'b0;
      align_q <= 1'b0;
    end else begin
      align_q <= 1'b0;
      case (aln_q)
        MCOS_ALN_IDLE: begin
          if (assert_w) begin
            aln_q <= MCOS_ALN_HELD;
            hold_q <= demux_w; // [R03] [R04]
          end
        end
        MCOS_ALN_HELD: begin
          if (release_w) begin
            aln_q <= MCOS_ALN_COUNT;
            cnt_q <= qtr_w ? MCOS_ALN_CYC_QTR : MCOS_ALN_CYC_ZERO; // [R06] [R07]
          end
        end
        MCOS_ALN_COUNT: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            aln_q <= MCOS_ALN_IDLE;
            hold_q <= 1'b0;
            align_q <= 1'b1;
          end
        end
        default: begin
          aln_q <= MCOS_ALN_IDLE;
          hold_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      seen_q <= 1'b0;
      npulse_q <= 8'h00;
    end else if (aln_q == MCOS_ALN_IDLE && assert_w) begin
      seen_q <= 1'b1;
      npulse_q <= (npulse_q == 8'hff) ? npulse_q : npulse_q + 8'h01;
    end
  end

  // phase counter: alignment edge first, then the master reference
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      phase_q <= 2'b00;
    end else if (aln_q == MCOS_ALN_COUNT && cnt_q == 3'h1) begin
      phase_q <= 2'b00; // [R09]
    end else if (ref_evt_w) begin
      phase_q <= psel_field_w; // [R14] [R17]
    end else begin
      phase_q <= phase_q + 2'b01;
    end
  end

  // demux divides by four with a selectable quarter offset
  assign phase_adj_w = phase_q + psel_field_w + {1'b0, qtr_w};
  assign clk_raw_w = hold_q | (demux_w ? phase_adj_w[1] : phase_adj_w[0]); // [R03] [R05]

  // latency plus output delay minus aperture delay
  assign tap_w = 5'(ALIGN_LAT + OUT_DLY) - {1'b0, aper_q}; // [R16]

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[DLY_LEN-2:0], clk_raw_w}; // [R08]
    end
  end

  // both channels share one source so they can never drift apart
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      in_phase_channel_out_clock <= 1'b0;
      quadrature_channel_out_clock <= 1'b0;
      sync_reference_out_a <= 1'b0;
      sync_reference_out_b <= 1'b0;
    end else begin
      in_phase_channel_out_clock <= dly_q[tap_w]; // [R13]
      quadrature_channel_out_clock <= dly_q[tap_w]; // [R13]
      sync_reference_out_a <= ms_en_w & ~ms_slave_w & phase_q[1];
      sync_reference_out_b <= ms_en_w & ~ms_slave_w & phase_q[1];
    end
  end

  // cycles since internal reset release, so the delay check never looks before time zero
  logic [4:0] warm_q;

  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      warm_q <= 5'h00;
    end else if (warm_q != 5'h1f) begin
      warm_q <= warm_q + 5'h01;
    end
  end

  // checks
  pulse_gate_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R01]
    (aln_q == MCOS_ALN_IDLE && !pulse_en_w) |=> aln_q == MCOS_ALN_IDLE)
    else $error("alignment sequence started while pulse reset disabled");
  sync_start_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R18]
    (aln_q == MCOS_ALN_COUNT && $past(aln_q) != MCOS_ALN_COUNT)
      |-> $past(pulse_s3_q) && !$past(pulse_s2_q))
    else $error("count started without a synchronised release");
  hold_high_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R03]
    (aln_q == MCOS_ALN_HELD && demux_w && $past(aln_q) == MCOS_ALN_HELD) |-> clk_raw_w)
    else $error("output clock not held high in demux mode");
  nodemux_run_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R04]
    (aln_q == MCOS_ALN_HELD && !demux_w && !ms_slave_w) |=> !hold_q ##0
    phase_q == $past(phase_q) + 2'b01)
    else $error("output clock stopped in non-demux mode");
  align_qtr_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R06]
    (aln_q == MCOS_ALN_HELD && release_w && qtr_w) |-> ##5 align_q)
    else $error("quarter phase alignment edge misplaced");
  align_zero_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R07]
    (aln_q == MCOS_ALN_HELD && release_w && !qtr_w) |-> !align_q [*6] ##1 align_q)
    else $error("zero phase alignment edge misplaced");
  det_exit_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R09]
    (align_q && !ms_slave_w) |-> phase_q == 2'b00 && !hold_q)
    else $error("alignment did not reset the phase");
  out_delay_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R16]
    (warm_q == 5'h1f && aper_q == 4'h0 && $past(aper_q) == 4'h0) |->
    in_phase_channel_out_clock == $past(clk_raw_w, 18))
    else $error("output clock delay does not match the pipeline");
  chan_phase_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R13]
    in_phase_channel_out_clock == quadrature_channel_out_clock)
    else $error("channel output clocks differ");
  slave_lock_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R15]
    (ref_evt_w && !(aln_q == MCOS_ALN_COUNT && cnt_q == 3'h1))
      |=> phase_q == $past(psel_field_w))
    else $error("slave did not lock to master reference");
  aln_cycle_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
    aln_q == MCOS_ALN_HELD ##[1:50] align_q);
  second_pulse_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
    align_q && npulse_q == 8'h02);
  slave_evt_c: cover property (@(posedge clk) disable iff (!rst_s2_q) ref_evt_w);
  apb_err_c: cover property (@(posedge clk) disable iff (!rst_s2_q) pready && pslverr);
  aper_shift_c: cover property (@(posedge clk) disable iff (!rst_s2_q)
    align_q && aper_q != 4'h0);

  ref_off_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R12]
    (!ms_en_w || ms_slave_w) |=> !sync_reference_out_a && !sync_reference_out_b)
    else $error("reference driven while not master");
  ref_pair_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R17]
    sync_reference_out_a == sync_reference_out_b)
    else $error("reference outputs differ");
  count_range_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R07]
    aln_q == MCOS_ALN_COUNT |-> cnt_q != 3'h0 && cnt_q <= MCOS_ALN_CYC_ZERO)
    else $error("alignment counter out of range");
  align_once_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R09]
    align_q |=> !align_q)
    else $error("alignment strobe longer than one cycle");
  idle_hold_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R08]
    aln_q == MCOS_ALN_IDLE |-> !hold_q)
    else $error("output clock still held while idle");
  held_wait_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R18]
    (aln_q == MCOS_ALN_HELD && !release_w) |=> aln_q == MCOS_ALN_HELD)
    else $error("hold left without a synchronised release");
  pulse_count_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R09]
    (aln_q == MCOS_ALN_IDLE && assert_w && npulse_q != 8'hff) |=> npulse_q == $past(npulse_q) + 8'h01)
    else $error("accepted pulse not counted");
  err_ready_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // [R12]
    pslverr |-> pready)
    else $error("error response without ready");
endmodule
`default_nettype wire

// File: verification/mcos_partner.sv
// mcos_partner: reference clock source standing in for a master converter
// assumes the bench wires link_clk straight to the device under test
`timescale 1ns/1ps
`default_nettype none
module mcos_partner #(
  parameter real HALF_NS = 7.5
) (
  // reference clock to the slave
  output var logic link_clk
);
  // free-running reference, phase unrelated to the sampling clock
  initial begin
    link_clk = 1'b0;
    #3.1;
    forever #(HALF_NS) link_clk = ~link_clk;
  end
endmodule
`default_nettype wire

// File: verification/tb_multi_chip_output_clock_sync.sv
// tb_multi_chip_output_clock_sync: apb-driven tests of output clock alignment
// assumes mcos_pkg and mcos_top compiled first, mcos_partner supplies link_clk
`timescale 1ns/1ps
`default_nettype none
module tb_multi_chip_output_clock_sync;
  import mcos_pkg::*;
  logic clk, rst_n, link_clk, psel, penable, pwrite, pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, ock_i, ock_q, ref_a, ref_b;
  int n_mismatch, comparisons, d1, d1b, d0, da, bad, tg;
  mcos_top mcos_top_inst (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_align_pulse(pulse),
    .in_phase_channel_out_clock(ock_i), .quadrature_channel_out_clock(ock_q),
    .sync_reference_out_a(ref_a), .sync_reference_out_b(ref_b));
  mcos_partner mcos_partner_inst (.link_clk(link_clk));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(32'(pready === 1'b1), 32'h0000_0001, "no ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input logic e, pe, dm, q, ms, sl, input logic [1:0] ps);
    cw = 32'h0000_0000;
    cw[MCOS_CTRL_ECM] = e;
    cw[MCOS_CTRL_PULSE_EN] = pe;
    cw[MCOS_CTRL_DEMUX] = dm;
    cw[MCOS_CTRL_QTR] = q;
    cw[MCOS_CTRL_MS_EN] = ms;
    cw[MCOS_CTRL_MS_SLAVE] = sl;
    cw[MCOS_CTRL_PSEL_LO +: 2] = ps;
  endfunction
  // pulse for hi cycles; late in it count low samples and toggles of the output
  // clock, then count cycles from release to its first falling edge
  task automatic pulse_run(input int hi, output int low_n, output int tog_n, output int dly);
    logic prev;
    low_n = 0;
    tog_n = 0;
    dly = 0;
    prev = ock_i;
    @(posedge clk);
    pulse <= 1'b1;
    for (int i = 0; i < hi; i++) begin
      @(posedge clk);
      if (i >= 24 && ock_i !== 1'b1) low_n++;
      if (i >= 24 && ock_i !== prev) tog_n++;
      prev = ock_i;
    end
    pulse <= 1'b0;
    while (dly < 80) begin
      @(posedge clk);
      dly++;
      if (prev === 1'b1 && ock_i === 1'b0) break;
      prev = ock_i;
    end
    repeat (30) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (rst_n === 1'b1) chk({31'h0, ock_q}, {31'h0, ock_i}, "channel clocks differ");
  end
  initial begin
    #80000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pulse = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, MCOS_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "ctrl after reset");
    apb(1'b0, MCOS_APER_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "aperture after reset");
    apb(1'b1, MCOS_APER_OFS, 32'hFFFF_FFFF);
    apb(1'b0, MCOS_APER_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_000F, "aperture width");
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    tend("registers");
    // pulse must not act unless both enables are set
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00));
    pulse_run(40, bad, tg, d1);
    chk(32'(bad > 0), 32'h0000_0001, "held without ecm");
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00));
    pulse_run(40, bad, tg, d1);
    chk(32'(bad > 0), 32'h0000_0001, "held while disabled");
    tend("disabled pulse");
    apb(1'b1, MCOS_APER_OFS, 32'h0000_0000);
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00));
    pulse_run(40, bad, tg, d1);
    pulse_run(40, bad, tg, d1);
    chk(32'(bad), 32'h0000_0000, "clock not held high");
    pulse_run(40, bad, tg, d1b);
    chk(32'(d1b), 32'(d1), "release not repeatable");
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'b00));
    pulse_run(40, bad, tg, d0);
    chk(32'(d0), 32'(d1 + 1), "zero phase edge");
    apb(1'b1, MCOS_APER_OFS, 32'h0000_0002);
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00));
    pulse_run(40, bad, tg, da);
    chk(32'(da), 32'(d1 - 2), "aperture shift");
    apb(1'b1, MCOS_APER_OFS, 32'h0000_0000);
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'b00));
    pulse_run(40, bad, tg, d0);
    chk(32'(tg > 0), 32'h0000_0001, "non-demux clock stopped");
    apb(1'b0, MCOS_STAT_OFS, 32'h0000_0000);
    chk(rd & 32'h0000_FF07, 32'h0000_0604, "six enabled pulses counted");
    tend("pulse alignment");
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, MCOS_CTRL_OFS, cw(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'(p)));
      // locked phase shows p just after each reference edge, then moves on
      tg = 0;
      repeat (16) begin
        apb(1'b0, MCOS_STAT_OFS, 32'h0000_0000);
        if (rd[5:4] === 2'(p)) tg++;
      end
      chk(32'(tg > 0 && tg < 16), 32'h0000_0001, "slave phase");
    end
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00));
    tg = 0;
    repeat (40) begin
      @(posedge clk);
      if (ref_a === 1'b1 && ref_b === 1'b1) tg++;
    end
    chk(32'(tg > 0 && tg < 40), 32'h0000_0001, "master reference idle");
    apb(1'b1, MCOS_CTRL_OFS, cw(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'b00));
    repeat (20) @(posedge clk);
    chk({30'h0, ref_a, ref_b}, 32'h0000_0000, "reference without master");
    tend("master slave");
    finish_test();
  end
endmodule
`default_nettype wire
